/* verif/pfg_override_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module pfg_override_bench;
    import pfg_pkg::*;
    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    pfg_bus_s    bus = '0;
    pfg_alt_s    alt = '0;
    logic [7:0]  pf_dir_bits = 8'h00, pf_out_bits = 8'h00;
    logic [4:0]  pg_dir_bits = 5'h00, pg_out_bits = 5'h00;
    logic [7:0]  pf_ext = 8'h00, pf_ext_en = 8'h00, pf_pin_i;
    logic [4:0]  pg_ext = 5'h00, pg_ext_en = 5'h00, pg_pin_i;
    logic [7:0]  bus_rdata, port_a_output_data, pf_o, pf_oe, pf_pu, pf_din;
    logic [4:0]  pg_o, pg_oe, pg_pu, pg_din;
    logic        bus_ack, bus_ext_access, global_pullup_off;
    logic        timer_osc_in, timer_osc_out, pu_dis_m = 1'b0;
    logic [15:0] lfsr_q = 16'h000f;
    int          fails = 0, cmp_count = 0, cyc = 0;

    always #5 core_clk = ~core_clk;

    pfg_override DUT (.core_clk(core_clk), .rstn(rstn), .bus(bus),
        .alt(alt), .pf_dir_bits(pf_dir_bits), .pf_out_bits(pf_out_bits),
        .pg_dir_bits(pg_dir_bits), .pg_out_bits(pg_out_bits),
        .pf_pin_i(pf_pin_i), .pg_pin_i(pg_pin_i), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .bus_ext_access(bus_ext_access),
        .port_a_output_data(port_a_output_data),
        .global_pullup_off(global_pullup_off), .pf_o(pf_o), .pf_oe(pf_oe),
        .pf_pu(pf_pu), .pf_din(pf_din), .pg_o(pg_o), .pg_oe(pg_oe),
        .pg_pu(pg_pu), .pg_din(pg_din), .timer_osc_in(timer_osc_in),
        .timer_osc_out(timer_osc_out));
    pfg_pin_model u_pins (.pf_o(pf_o), .pf_oe(pf_oe), .pf_pu(pf_pu),
        .pg_o(pg_o), .pg_oe(pg_oe), .pg_pu(pg_pu), .pf_ext(pf_ext),
        .pf_ext_en(pf_ext_en), .pg_ext(pg_ext), .pg_ext_en(pg_ext_en),
        .core_clk(core_clk), .pf_pin(pf_pin_i), .pg_pin(pg_pin_i));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] npu(input logic [7:0] d, o);
        return ~d & o & {8{~pu_dis_m}};
    endfunction
    task automatic rnd();
        lfsr_q = lfsr(lfsr_q);
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input logic [7:0] got, exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    task automatic acc(input logic sio, input logic [7:0] a, input logic w,
                       input logic [7:0] wd, rd, input logic [1:0] resp);
        bus = '{short_io: sio, addr: a, wr: w, rd: ~w, wdata: wd};
        step(1);
        chk(8'({bus_ack, bus_ext_access}), 8'(resp), "response");
        if (!w) chk(bus_rdata, rd, "read data");
        bus = '0;
        step(1);
    endtask
    task automatic pads();
        logic [7:0] fpu, foe, fo;
        logic [4:0] gpu, goe, go;
        logic       osc, mem;
        fpu = npu(pf_dir_bits, pf_out_bits);
        foe = pf_dir_bits;
        fo = pf_out_bits;
        gpu = 5'(npu(8'(pg_dir_bits), 8'(pg_out_bits)));
        goe = pg_dir_bits;
        go = pg_out_bits;
        osc = alt.async_timer_clock_select | alt.legacy_mode;
        mem = alt.external_memory_enable | alt.legacy_mode;
        if (alt.test_port_enable) begin
            fpu[7:4] = 4'hb;
            foe[7:4] = {1'b0, alt.shift_ir | alt.shift_dr, 2'h0};
            fo[6] = alt.tdo_data;
        end
        if (osc) begin
            gpu[4:3] = 2'h0;
            goe[4:3] = 2'h0;
        end
        if (mem) begin
            gpu[2:0] = 3'h0;
            goe[2:0] = 3'h7;
            go[2:0] = {alt.ale, alt.rd_strobe, alt.wr_strobe};
        end
        step(1);
        chk(pf_pu, fpu, "pf pull-up");
        chk(pf_oe, foe, "pf direction");
        chk(pf_o & foe, fo & foe, "pf value");
        chk(8'(pg_pu), 8'(gpu), "pg pull-up");
        chk(8'(pg_oe), 8'(goe), "pg direction");
        chk(8'(pg_o & goe), 8'(go & goe), "pg value");
        chk(8'({timer_osc_in, timer_osc_out}), 8'({osc, osc}), "osc");
    endtask
    task automatic pad_loop();
        for (int i = 0; i < 40; i++) begin
            rnd();
            alt = pfg_alt_s'(lfsr_q[9:0]);
            pf_dir_bits = lfsr_q[15:8];
            rnd();
            pf_out_bits = lfsr_q[7:0];
            pg_dir_bits = lfsr_q[12:8];
            rnd();
            pg_out_bits = lfsr_q[4:0];
            pads();
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        step(5);
        rstn = 1'b1;
        acc(1, PFG_OFS_PORT_A, 0, 8'h00, PFG_PORT_A_RST, 2'b10);
        acc(1, PFG_OFS_MISC, 0, 8'h00, PFG_MISC_RST, 2'b10);
        for (int i = 0; i < 3; i++) begin
            rnd();
            acc(~i[0], i[0] ? 8'h3b : PFG_OFS_PORT_A, 1,
                lfsr_q[7:0], 8'h00, 2'b10);
            chk(port_a_output_data, lfsr_q[7:0], "port a");
            acc(0, 8'h3b, 0, 8'h00, lfsr_q[7:0], 2'b10);
        end
        acc(0, 8'h1b, 1, ~lfsr_q[7:0], PFG_RDATA_NONE, 2'b00);
        acc(0, 8'h60, 1, ~lfsr_q[7:0], PFG_RDATA_NONE, 2'b01);
        acc(1, 8'h40, 0, 8'h00, PFG_RDATA_NONE, 2'b00);
        chk(port_a_output_data, lfsr_q[7:0], "port a kept");
        acc(0, 8'h40, 1, 8'hff, 8'h00, 2'b10);
        pu_dis_m = 1'b1;
        acc(1, PFG_OFS_MISC, 0, 8'h00, PFG_MISC_MASK, 2'b10);
        chk(8'(global_pullup_off), 8'h01, "pull-up off");
        pad_loop();
        acc(1, PFG_OFS_MISC, 1, 8'h00, 8'h00, 2'b10);
        pu_dis_m = 1'b0;
        pad_loop();
        alt = '{test_port_enable: 1'b1, async_timer_clock_select: 1'b1,
                default: 1'b0};
        pf_dir_bits = 8'h00;
        pg_dir_bits = 5'h00;
        pf_ext_en = 8'hff;
        pg_ext_en = 5'h1f;
        rnd();
        pf_ext = lfsr_q[7:0];
        pg_ext = lfsr_q[12:8];
        step(4);
        chk(pf_din, {4'h0, pf_ext[3:0]}, "pf input");
        chk(8'(pg_din), {5'h0, pg_ext[2:0]}, "pg input");
        alt = '0;
        step(4);
        chk(pf_din, pf_ext, "pf input plain");
        chk(8'(pg_din), 8'(pg_ext), "pg input plain");
        conclude();
    end
endmodule

bind pfg_override pfg_override_props u_props (.core_clk(core_clk),
    .rstn(rstn), .bus(bus), .alt(alt), .pf_dir_bits(pf_dir_bits),
    .pf_out_bits(pf_out_bits), .bus_ack(bus_ack),
    .bus_ext_access(bus_ext_access), .port_a_output_data(port_a_output_data),
    .global_pullup_off(global_pullup_off), .pf_o(pf_o), .pf_oe(pf_oe),
    .pf_pu(pf_pu), .pf_din(pf_din), .pg_o(pg_o), .pg_oe(pg_oe),
    .pg_pu(pg_pu), .timer_osc_in(timer_osc_in),
    .timer_osc_out(timer_osc_out));
`default_nettype wire

/* verif/pfg_override_props.sv */
`timescale 1ns/100ps
`default_nettype none
module pfg_override_props (
    input wire logic              core_clk,
    input wire logic              rstn,
    input wire pfg_pkg::pfg_bus_s bus,
    input wire pfg_pkg::pfg_alt_s alt,
    input wire logic [7:0]        pf_dir_bits,
    input wire logic [7:0]        pf_out_bits,
    input wire logic              bus_ack,
    input wire logic              bus_ext_access,
    input wire logic [7:0]        port_a_output_data,
    input wire logic              global_pullup_off,
    input wire logic [7:0]        pf_o,
    input wire logic [7:0]        pf_oe,
    input wire logic [7:0]        pf_pu,
    input wire logic [7:0]        pf_din,
    input wire logic [4:0]        pg_o,
    input wire logic [4:0]        pg_oe,
    input wire logic [4:0]        pg_pu,
    input wire logic              timer_osc_in,
    input wire logic              timer_osc_out
);
    import pfg_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_test_pullups: assert property (alt.test_port_enable |=>
        pf_pu[7:4] == 4'hb) else $error("test pull-ups wrong");
    a_test_dirs: assert property (alt.test_port_enable [*3] |->
        {pf_oe[7], pf_oe[5:4]} == 3'h0 && pf_din[7:4] == 4'h0)
        else $error("test pins not inputs");
    a_tdo_drive: assert property (alt.test_port_enable |=>
        pf_oe[6] == $past(alt.shift_ir || alt.shift_dr)
        && pf_o[6] == $past(alt.tdo_data)) else $error("tdo wrong");
    a_lower_plain: assert property (1'b1 |=>
        pf_oe[3:0] == $past(pf_dir_bits[3:0]) && (pf_o[3:0] & pf_oe[3:0])
        == ($past(pf_out_bits[3:0]) & pf_oe[3:0]))
        else $error("lower port f overridden");
    a_osc_release: assert property (alt.async_timer_clock_select |=>
        pg_oe[4:3] == 2'h0 && pg_pu[4:3] == 2'h0 && timer_osc_in
        && timer_osc_out) else $error("oscillator pins wrong");
    a_mem_strobes: assert property (alt.external_memory_enable |=>
        pg_oe[2:0] == 3'h7 && pg_pu[2:0] == 3'h0 && pg_o[2:0] ==
        {$past(alt.ale), $past(alt.rd_strobe), $past(alt.wr_strobe)})
        else $error("memory strobes wrong");
    a_legacy_alt: assert property (alt.legacy_mode |=>
        pg_oe == 5'h07 && timer_osc_in) else $error("legacy pins wrong");
    a_pud_gate: assert property (global_pullup_off |=>
        pf_pu[3:0] == 4'h0 && pg_pu == 5'h00) else $error("pull-up on");
    a_port_a_output_data_write: assert property (bus.wr && !bus.short_io &&
        bus.addr == 8'h3b |=> bus_ack
        && port_a_output_data == $past(bus.wdata)) else $error("port a");
    a_ext_space: assert property ((bus.rd || bus.wr) &&
        !bus.short_io && bus.addr >= 8'h60 |=> bus_ext_access && !bus_ack)
        else $error("extended access wrong");

    c_tdo_shift: cover property (alt.test_port_enable && alt.shift_dr);
    c_mem_read: cover property (alt.external_memory_enable ##1 pg_o[1]);
    c_ext_hit: cover property (bus_ext_access);
endmodule
`default_nettype wire

/* verif/pfg_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pfg_pin_model (
    input  wire logic [7:0] pf_o,
    input  wire logic [7:0] pf_oe,
    input  wire logic [7:0] pf_pu,
    input  wire logic [4:0] pg_o,
    input  wire logic [4:0] pg_oe,
    input  wire logic [4:0] pg_pu,
    input  wire logic [7:0] pf_ext,
    input  wire logic [7:0] pf_ext_en,
    input  wire logic [4:0] pg_ext,
    input  wire logic [4:0] pg_ext_en,
    input  wire logic       core_clk,
    output logic [7:0]      pf_pin,
    output logic [4:0]      pg_pin
);
    logic float_q = 1'b0;
    // An undriven pin without pull-up wanders every cycle
    always_ff @(posedge core_clk) begin
        float_q <= ~float_q;
    end
    assign pf_pin = (pf_oe & pf_o) | (~pf_oe & pf_ext_en & pf_ext)
        | (~pf_oe & ~pf_ext_en & (pf_pu | {8{float_q}}));
    assign pg_pin = (pg_oe & pg_o) | (~pg_oe & pg_ext_en & pg_ext)
        | (~pg_oe & ~pg_ext_en & (pg_pu | {5{float_q}}));
endmodule
`default_nettype wire

/* verilog/pfg_override.sv */
`timescale 1ns/100ps
`default_nettype none

module pfg_pin_cell (
    input  wire pfg_pkg::pfg_ovr_s ovr,
    input  wire logic              dir_bit,
    input  wire logic              out_bit,
    input  wire logic              pullup_off,
    output var pfg_pkg::pfg_pad_s  pad
);
    import pfg_pkg::*;

    logic pu_norm;

    assign pu_norm = ~dir_bit & out_bit & ~pullup_off;

    always_comb begin
        pad.pu = ovr.pu_en  ? ovr.pu_val  : pu_norm;
        pad.oe = ovr.dir_en ? ovr.dir_val : dir_bit;
        pad.o  = ovr.val_en ? ovr.val_val : out_bit;
        pad.ie = ovr.ie_en  ? ovr.ie_val  : 1'b1;
    end
endmodule

module pfg_override (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire pfg_pkg::pfg_bus_s         bus,
    input  wire pfg_pkg::pfg_alt_s         alt,
    input  wire logic [pfg_pkg::PFG_PF_W-1:0] pf_dir_bits,
    input  wire logic [pfg_pkg::PFG_PF_W-1:0] pf_out_bits,
    input  wire logic [pfg_pkg::PFG_PG_W-1:0] pg_dir_bits,
    input  wire logic [pfg_pkg::PFG_PG_W-1:0] pg_out_bits,
    input  wire logic [pfg_pkg::PFG_PF_W-1:0] pf_pin_i,
    input  wire logic [pfg_pkg::PFG_PG_W-1:0] pg_pin_i,
    output logic [7:0]                     bus_rdata,
    output logic                           bus_ack,
    output logic                           bus_ext_access,
    output logic [7:0]                     port_a_output_data,
    output logic                           global_pullup_off,
    output logic [pfg_pkg::PFG_PF_W-1:0]   pf_o,
    output logic [pfg_pkg::PFG_PF_W-1:0]   pf_oe,
    output logic [pfg_pkg::PFG_PF_W-1:0]   pf_pu,
    output logic [pfg_pkg::PFG_PF_W-1:0]   pf_din,
    output logic [pfg_pkg::PFG_PG_W-1:0]   pg_o,
    output logic [pfg_pkg::PFG_PG_W-1:0]   pg_oe,
    output logic [pfg_pkg::PFG_PG_W-1:0]   pg_pu,
    output logic [pfg_pkg::PFG_PG_W-1:0]   pg_din,
    output logic                           timer_osc_in,
    output logic                           timer_osc_out
);
    import pfg_pkg::*;

    localparam logic [7:0] DS_PORT_A = PFG_OFS_PORT_A + PFG_DS_IO_BASE;
    localparam logic [7:0] DS_MISC   = PFG_OFS_MISC + PFG_DS_IO_BASE;

    logic [7:0]          port_a_q;
    logic [7:0]          misc_q;
    logic [7:0]          rdata_q;
    logic                ack_q;
    logic                ext_q;
    logic                pu_dis;

    logic [7:0]          eff_addr;
    logic                addr_ok;
    logic                hit_port_a;
    logic                hit_misc;
    logic                hit_ext;
    logic                access;

    pfg_ovr_s            pf_ovr [PFG_PF_W];
    pfg_ovr_s            pg_ovr [PFG_PG_W];
    pfg_pad_s            pf_pad [PFG_PF_W];
    pfg_pad_s            pg_pad [PFG_PG_W];

    logic [PFG_PF_W-1:0] pf_meta_q;
    logic [PFG_PF_W-1:0] pf_sync_q;
    logic [PFG_PG_W-1:0] pg_meta_q;
    logic [PFG_PG_W-1:0] pg_sync_q;

    logic [PFG_PF_W-1:0] pf_o_q;
    logic [PFG_PF_W-1:0] pf_oe_q;
    logic [PFG_PF_W-1:0] pf_pu_q;
    logic [PFG_PF_W-1:0] pf_din_q;
    logic [PFG_PG_W-1:0] pg_o_q;
    logic [PFG_PG_W-1:0] pg_oe_q;
    logic [PFG_PG_W-1:0] pg_pu_q;
    logic [PFG_PG_W-1:0] pg_din_q;
    logic                osc_in_q;
    logic                osc_out_q;

    logic                jtag_on;
    logic                osc_on;
    logic                xmem_on;

    assign pu_dis = misc_q[PFG_PU_DIS_BIT];

    // Address decode of the core I/O bus
    always_comb begin
        eff_addr = bus.addr;
        addr_ok  = 1'b1;
        if (bus.short_io) begin
            addr_ok  = (bus.addr <= PFG_IO_TOP);
            eff_addr = bus.addr + PFG_DS_IO_BASE;
        end
    end

    assign access     = bus.rd | bus.wr;
    assign hit_port_a = addr_ok & (eff_addr == DS_PORT_A);
    assign hit_misc   = addr_ok & (eff_addr == DS_MISC);
    // extended space by data access only
    assign hit_ext    = ~bus.short_io & (bus.addr >= PFG_DS_EXT_BASE);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            port_a_q <= PFG_PORT_A_RST;
        end else if (bus.wr && hit_port_a) begin
            port_a_q <= bus.wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            misc_q <= PFG_MISC_RST;
        end else if (bus.wr && hit_misc) begin
            misc_q <= bus.wdata & PFG_MISC_MASK;
        end
    end

    // Read data and access acknowledge, one cycle after the request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= PFG_RDATA_NONE;
            ack_q   <= 1'b0;
            ext_q   <= 1'b0;
        end else begin
            ack_q <= access & (hit_port_a | hit_misc);
            ext_q <= access & hit_ext;
            if (bus.rd && hit_port_a) begin
                rdata_q <= port_a_q;
            end else if (bus.rd && hit_misc) begin
                rdata_q <= misc_q;
            end else begin
                rdata_q <= PFG_RDATA_NONE;
            end
        end
    end

    assign jtag_on = alt.test_port_enable;
    // legacy mode keeps Port G on its alternate functions
    assign osc_on  = alt.async_timer_clock_select | alt.legacy_mode;
    assign xmem_on = alt.external_memory_enable | alt.legacy_mode;

    // Port F override sets
    always_comb begin
        for (int i = 0; i < PFG_PF_W; i++) begin
            pf_ovr[i] = PFG_OVR_NONE;
        end
        for (int i = PFG_PF_TCK; i <= PFG_PF_TDI; i++) begin
            pf_ovr[i].dir_en  = jtag_on;
            pf_ovr[i].dir_val = 1'b0;
            pf_ovr[i].ie_en   = jtag_on;
            pf_ovr[i].ie_val  = 1'b0;
            pf_ovr[i].pu_en   = jtag_on;
            pf_ovr[i].pu_val  = (i != PFG_PF_TDO);
        end
        pf_ovr[PFG_PF_TDO].dir_val = alt.shift_ir | alt.shift_dr;
        pf_ovr[PFG_PF_TDO].val_en  = jtag_on;
        pf_ovr[PFG_PF_TDO].val_val = alt.tdo_data;
    end

    // Port G override sets
    always_comb begin
        for (int i = 0; i < PFG_PG_W; i++) begin
            pg_ovr[i] = PFG_OVR_NONE;
        end
        for (int i = PFG_PG_OSC_OUT; i <= PFG_PG_OSC_IN; i++) begin
            // neither oscillator pin usable as I/O
            pg_ovr[i].pu_en   = osc_on;
            pg_ovr[i].pu_val  = 1'b0;
            pg_ovr[i].dir_en  = osc_on;
            pg_ovr[i].dir_val = 1'b0;
            pg_ovr[i].ie_en   = osc_on;
            pg_ovr[i].ie_val  = 1'b0;
        end
        for (int i = PFG_PG_WR; i <= PFG_PG_ALE; i++) begin
            pg_ovr[i].pu_en   = xmem_on;
            pg_ovr[i].pu_val  = 1'b0;
            pg_ovr[i].dir_en  = xmem_on;
            pg_ovr[i].dir_val = 1'b1;
            pg_ovr[i].val_en  = xmem_on;
        end
        pg_ovr[PFG_PG_ALE].val_val = alt.ale;
        pg_ovr[PFG_PG_RD].val_val  = alt.rd_strobe;
        pg_ovr[PFG_PG_WR].val_val  = alt.wr_strobe;
    end

    for (genvar i = 0; i < PFG_PF_W; i++) begin : g_pf
        pfg_pin_cell u_cell (
            .ovr        (pf_ovr[i]),
            .dir_bit    (pf_dir_bits[i]),
            .out_bit    (pf_out_bits[i]),
            .pullup_off (pu_dis),
            .pad        (pf_pad[i])
        );
    end

    for (genvar i = 0; i < PFG_PG_W; i++) begin : g_pg
        pfg_pin_cell u_cell (
            .ovr        (pg_ovr[i]),
            .dir_bit    (pg_dir_bits[i]),
            .out_bit    (pg_out_bits[i]),
            .pullup_off (pu_dis),
            .pad        (pg_pad[i])
        );
    end

    // Pin input synchronisers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pf_meta_q <= '0;
            pf_sync_q <= '0;
            pg_meta_q <= '0;
            pg_sync_q <= '0;
        end else begin
            pf_meta_q <= pf_pin_i;
            pf_sync_q <= pf_meta_q;
            pg_meta_q <= pg_pin_i;
            pg_sync_q <= pg_meta_q;
        end
    end

    // Registered Port F pad controls
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pf_o_q   <= '0;
            pf_oe_q  <= '0;
            pf_pu_q  <= '0;
            pf_din_q <= '0;
        end else begin
            for (int i = 0; i < PFG_PF_W; i++) begin
                pf_o_q[i]   <= pf_pad[i].o;
                pf_oe_q[i]  <= pf_pad[i].oe;
                pf_pu_q[i]  <= pf_pad[i].pu;
                pf_din_q[i] <= pf_sync_q[i] & pf_pad[i].ie;
            end
        end
    end

    // Registered Port G pad controls
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pg_o_q   <= '0;
            pg_oe_q  <= '0;
            pg_pu_q  <= '0;
            pg_din_q <= '0;
        end else begin
            for (int i = 0; i < PFG_PG_W; i++) begin
                pg_o_q[i]   <= pg_pad[i].o;
                pg_oe_q[i]  <= pg_pad[i].oe;
                pg_pu_q[i]  <= pg_pad[i].pu;
                pg_din_q[i] <= pg_sync_q[i] & pg_pad[i].ie;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            osc_in_q  <= 1'b0;
            osc_out_q <= 1'b0;
        end else begin
            osc_in_q  <= osc_on;
            osc_out_q <= osc_on;
        end
    end

    assign bus_rdata          = rdata_q;
    assign bus_ack            = ack_q;
    assign bus_ext_access     = ext_q;
    assign port_a_output_data = port_a_q;
    assign global_pullup_off  = pu_dis;
    assign pf_o               = pf_o_q;
    assign pf_oe              = pf_oe_q;
    assign pf_pu              = pf_pu_q;
    assign pf_din             = pf_din_q;
    assign pg_o               = pg_o_q;
    assign pg_oe              = pg_oe_q;
    assign pg_pu              = pg_pu_q;
    assign pg_din             = pg_din_q;
    assign timer_osc_in       = osc_in_q;
    assign timer_osc_out      = osc_out_q;

endmodule
`default_nettype wire

/* verilog/pfg_pkg.sv */
`default_nettype none
package pfg_pkg;

    // Pin counts of the two ports handled here
    localparam int unsigned PFG_PF_W = 8;
    localparam int unsigned PFG_PG_W = 5;

    // Port F upper pins claimed by the test port
    localparam int unsigned PFG_PF_TCK = 4;
    localparam int unsigned PFG_PF_TMS = 5;
    localparam int unsigned PFG_PF_TDO = 6;
    localparam int unsigned PFG_PF_TDI = 7;

    // Port G pins
    localparam int unsigned PFG_PG_WR      = 0;
    localparam int unsigned PFG_PG_RD      = 1;
    localparam int unsigned PFG_PG_ALE     = 2;
    localparam int unsigned PFG_PG_OSC_OUT = 3;
    localparam int unsigned PFG_PG_OSC_IN  = 4;

    // Address map: short I/O range, data-space offset, extended space
    localparam logic [7:0] PFG_IO_TOP      = 8'h3f;
    localparam logic [7:0] PFG_DS_IO_BASE  = 8'h20;
    localparam logic [7:0] PFG_DS_EXT_BASE = 8'h60;
    localparam logic [7:0] PFG_OFS_PORT_A  = 8'h1b;
    localparam logic [7:0] PFG_OFS_MISC    = 8'h20;

    // Reset values and implemented bits
    localparam logic [7:0] PFG_PORT_A_RST  = 8'h00;
    localparam logic [7:0] PFG_MISC_RST    = 8'h00;
    localparam int unsigned PFG_PU_DIS_BIT = 2;
    localparam logic [7:0] PFG_MISC_MASK   = 8'h04;
    localparam logic [7:0] PFG_RDATA_NONE  = 8'h00;

    // One override set for one pin
    typedef struct packed {
        logic pu_en;
        logic pu_val;
        logic dir_en;
        logic dir_val;
        logic val_en;
        logic val_val;
        logic ie_en;
        logic ie_val;
    } pfg_ovr_s;

    localparam pfg_ovr_s PFG_OVR_NONE = '0;

    // Resolved control for one pad
    typedef struct packed {
        logic pu;
        logic oe;
        logic o;
        logic ie;
    } pfg_pad_s;

    // Core I/O register bus request
    typedef struct packed {
        logic       short_io;
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } pfg_bus_s;

    // Alternate-function controls from the test port, timer and memory
    typedef struct packed {
        logic test_port_enable;
        logic shift_ir;
        logic shift_dr;
        logic tdo_data;
        logic async_timer_clock_select;
        logic external_memory_enable;
        logic ale;
        logic rd_strobe;
        logic wr_strobe;
        logic legacy_mode;
    } pfg_alt_s;

endpackage
`default_nettype wire
